/* File: design/dcc_pkg.sv */
package dcc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_DIS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_WP_MODE  = 8'hE4;
  localparam logic [7:0] OFF_WP_STAT  = 8'hE8;
  localparam logic [7:0] OFF_VERSION  = 8'hFC;
  // mode register fields
  localparam int MODE_EXT_TRIG_BIT = 0;
  localparam int MODE_SRC_LSB      = 1;
  localparam int MODE_SRC_W        = 3;
  localparam int MODE_ENABLE_BIT   = 4;
  localparam int MODE_WORD_BIT     = 5;
  localparam int MODE_STARTUP_LSB  = 8;
  localparam int MODE_STARTUP_W    = 8;
  localparam int MODE_DIV_LSB      = 16;
  localparam int MODE_DIV_W        = 16;
  localparam logic [31:0] MODE_WRITE_MASK = 32'hFFFF_FF3F;
  localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
  // sample layout
  localparam int SAMPLE_W       = 10;
  localparam int SAMPLE_HI_LSB  = 16;
  localparam int FIFO_DEPTH     = 4;
  // trigger source codes
  localparam logic [2:0] SRC_PIN   = 3'h0;
  localparam logic [2:0] SRC_EVENT = 3'h1;
  // write protection key, interrupt and soft reset bits
  localparam logic [23:0] PROTECT_KEY = 24'h444143;
  localparam int KEY_LSB = 8;
  localparam int TX_ACCEPT_BIT = 0;
  localparam int SOFT_RESET_BIT = 0;
  // arbitrary version value
  localparam logic [31:0] VERSION_VALUE = 32'h0000_0001;
endpackage : dcc_pkg

/* File: design/dcc_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dcc_fifo_if #(parameter int W = 10);
  logic         flush;
  logic         push_one;
  logic         push_two;
  logic [W-1:0] din_first;
  logic [W-1:0] din_second;
  logic         pop;
  logic [W-1:0] dout;
  logic         empty;
  logic [2:0]   level;
  modport owner (output flush, push_one, push_two, din_first, din_second, pop, input dout, empty, level);
  modport store (input flush, push_one, push_two, din_first, din_second, pop, output dout, empty, level);
endinterface : dcc_fifo_if
`default_nettype wire

/* File: design/dcc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 4
) (
  input wire logic hclk,          // bus clock
  input wire logic hresetn,       // async reset, active low
  dcc_fifo_if.store f             // queue port
);
  logic [W-1:0] mem_q [DEPTH];
  logic [1:0]   rd_q;
  logic [1:0]   wr_q;
  logic [2:0]   cnt_q;
  logic [2:0]   n_in;

  assign n_in    = f.push_two ? 3'h2 : (f.push_one ? 3'h1 : 3'h0);
  assign f.dout  = mem_q[rd_q];
  assign f.empty = (cnt_q == 3'h0);
  assign f.level = cnt_q;

  // first-in first-out order
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 2'h0;
      wr_q  <= 2'h0;
      cnt_q <= 3'h0;
    end else if (f.flush) begin
      rd_q  <= 2'h0;
      wr_q  <= 2'h0;
      cnt_q <= 3'h0;
    end else begin
      wr_q  <= wr_q + n_in[1:0];
      rd_q  <= rd_q + {1'b0, f.pop};
      cnt_q <= cnt_q + n_in - {2'h0, f.pop};
    end
  end

  always_ff @(posedge hclk) begin
    if (f.push_one || f.push_two) begin
      mem_q[wr_q] <= f.din_first;
    end
    if (f.push_two) begin
      mem_q[wr_q + 2'h1] <= f.din_second;
    end
  end
endmodule : dcc_fifo
`default_nettype wire

/* File: design/dcc_ctrl.sv */
// Operation
// - all timing, triggers and queue run on the one bus clock.
// - ready only after startup plus one clocks from enable.
// - samples are ten bits wide.
// - four-entry queue, drained in write order.
// - data writes while ready are queued as conversions.
// - ready flag low when queue full, disabled or starting.
// - half-word takes bits 9:0; word adds bits 25:16 second.
// - word select 0 is half-word, 1 is two-sample word.
// - internal mode converts on enabled, queued and internal tick.
// - internal tick every divider clocks.
// - external mode source 0 is pin, 1 is event input.
// - pin source converts on rising pin edge.
// - event source converts on event arrival.
// - protect bit changes only with the correct key or a soft reset.
// - protected mode writes are dropped and error recorded.
// - a rejected mode write sets the protection error flag; a wrong-key write does not.
// - enable-register ones set mask, disable-register ones clear.
// - soft reset command clears mode, protection, mask, startup and queue; analog_data keeps its last sample.
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl (
  input  wire logic        hclk,         // bus clock, 40 MHz
  input  wire logic        hresetn,      // async reset, active low
  input  wire logic        hsel,         // slave select
  input  wire logic [31:0] haddr,        // byte address
  input  wire logic [1:0]  htrans,       // transfer type
  input  wire logic        hwrite,       // write not read
  input  wire logic [2:0]  hsize,        // transfer size
  input  wire logic        hready,       // bus ready in
  input  wire logic [31:0] hwdata,       // write data
  output logic      [31:0] hrdata,       // read data
  output logic             hreadyout,    // slave ready
  output logic             hresp,        // response, always okay
  input  wire logic        trig_pin,     // external trigger pin
  input  wire logic        event_in,     // event router pulse
  output logic      [9:0]  analog_data,  // sample to analog core
  output logic             conv_strobe,  // one-cycle conversion start
  output logic             analog_on,    // analog core enable
  output logic             irq           // interrupt request
);
  dcc_fifo_if #(.W(dcc_pkg::SAMPLE_W)) fq ();

  dcc_fifo #(.W(dcc_pkg::SAMPLE_W), .DEPTH(dcc_pkg::FIFO_DEPTH)) u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .f       (fq.store)
  );

  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        rd_pend_q;
  logic [7:0]  rd_addr_q;
  logic [31:0] mode_q;
  logic        wp_on_q;
  logic        wp_err_q;
  logic        mask_q;
  logic        ready_q;
  logic [8:0]  start_cnt_q;
  logic [15:0] div_cnt_q;
  logic        pin_q;
  logic        soft_rst;
  logic        enabled;
  logic        ext_mode;
  logic [2:0]  src_sel;
  logic        word_mode;
  logic        tick;
  logic        trig;
  logic        tx_accept;
  logic        data_wr;
  logic        wp_rd;
  logic        take;

  assign enabled   = mode_q[dcc_pkg::MODE_ENABLE_BIT];
  assign ext_mode  = mode_q[dcc_pkg::MODE_EXT_TRIG_BIT];
  assign src_sel   = mode_q[dcc_pkg::MODE_SRC_LSB +: dcc_pkg::MODE_SRC_W];
  assign word_mode = mode_q[dcc_pkg::MODE_WORD_BIT];
  assign soft_rst  = wr_pend_q && (wr_addr_q == dcc_pkg::OFF_CTRL)
                     && hwdata[dcc_pkg::SOFT_RESET_BIT];
  assign data_wr   = wr_pend_q && (wr_addr_q == dcc_pkg::OFF_DATA);
  assign wp_rd     = rd_pend_q && (rd_addr_q == dcc_pkg::OFF_WP_STAT);
  assign take      = hsel && hready && htrans[1];

  // one-sample room needed in half-word, two in word mode
  // gated by enable so a disable drops ready in the same cycle
  assign tx_accept = ready_q && enabled && (fq.level <= (word_mode ? 3'h2 : 3'h3));

  // address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) begin
        wr_addr_q <= {haddr[7:2], 2'h0};
        rd_addr_q <= {haddr[7:2], 2'h0};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read mux, registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case ({haddr[7:2], 2'h0})
        dcc_pkg::OFF_MODE:     hrdata <= mode_q;
        dcc_pkg::OFF_IRQ_MASK: hrdata <= {31'h0, mask_q};
        dcc_pkg::OFF_IRQ_STAT: hrdata <= {31'h0, tx_accept};
        dcc_pkg::OFF_WP_MODE:  hrdata <= {31'h0, wp_on_q};
        dcc_pkg::OFF_WP_STAT:  hrdata <= {31'h0, wp_err_q};
        dcc_pkg::OFF_VERSION:  hrdata <= dcc_pkg::VERSION_VALUE;
        default:               hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // mode register, guarded by write protection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= dcc_pkg::MODE_RESET;
    end else if (soft_rst) begin
      mode_q <= dcc_pkg::MODE_RESET;
    end else if (wr_pend_q && wr_addr_q == dcc_pkg::OFF_MODE && !wp_on_q) begin
      mode_q <= hwdata & dcc_pkg::MODE_WRITE_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_on_q <= 1'b0;
    end else if (soft_rst) begin
      wp_on_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == dcc_pkg::OFF_WP_MODE
                 && hwdata[31:dcc_pkg::KEY_LSB] == dcc_pkg::PROTECT_KEY) begin
      wp_on_q <= hwdata[0];
    end
  end

  // error flag clears on status read; a new error in that cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_err_q <= 1'b0;
    end else if (soft_rst) begin
      wp_err_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == dcc_pkg::OFF_MODE && wp_on_q) begin
      wp_err_q <= 1'b1;
    end else if (wp_rd) begin
      wp_err_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= 1'b0;
    end else if (soft_rst) begin
      mask_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == dcc_pkg::OFF_IRQ_EN && hwdata[dcc_pkg::TX_ACCEPT_BIT]) begin
      mask_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == dcc_pkg::OFF_IRQ_DIS && hwdata[dcc_pkg::TX_ACCEPT_BIT]) begin
      mask_q <= 1'b0;
    end
  end

  // startup delay: count STARTUP+1 clocks after enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_cnt_q <= 9'h000;
      ready_q     <= 1'b0;
    end else if (!enabled || soft_rst) begin
      start_cnt_q <= 9'h000;
      ready_q     <= 1'b0;
    end else if (!ready_q) begin
      if (start_cnt_q == {1'b0, mode_q[dcc_pkg::MODE_STARTUP_LSB +: dcc_pkg::MODE_STARTUP_W]}) begin
        ready_q <= 1'b1;
      end else begin
        start_cnt_q <= start_cnt_q + 9'h001;
      end
    end
  end

  // internal tick divider on the bus clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 16'h0000;
    end else if (!enabled || soft_rst || tick) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end
  assign tick = enabled
                && (div_cnt_q + 16'h0001 >= mode_q[dcc_pkg::MODE_DIV_LSB +: dcc_pkg::MODE_DIV_W]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= trig_pin;
    end
  end

  always_comb begin
    if (!ext_mode) begin
      trig = tick;
    end else begin
      case (src_sel)
        dcc_pkg::SRC_PIN:   trig = trig_pin && !pin_q;
        dcc_pkg::SRC_EVENT: trig = event_in;
        default:            trig = 1'b0;
      endcase
    end
  end

  // queue control; data writes are pushed only while the ready flag is set
  assign fq.flush      = !enabled || soft_rst;
  assign fq.push_one   = data_wr && tx_accept && !word_mode;
  assign fq.push_two   = data_wr && tx_accept && word_mode;
  assign fq.din_first  = hwdata[dcc_pkg::SAMPLE_W-1:0];
  assign fq.din_second = hwdata[dcc_pkg::SAMPLE_HI_LSB +: dcc_pkg::SAMPLE_W];
  assign fq.pop        = ready_q && enabled && !soft_rst && !fq.empty && trig;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_data <= 10'h000;
      conv_strobe <= 1'b0;
      analog_on   <= 1'b0;
      irq         <= 1'b0;
    end else begin
      conv_strobe <= fq.pop;
      analog_on   <= enabled && !soft_rst;
      irq         <= tx_accept && mask_q && !soft_rst;
      if (fq.pop) begin
        analog_data <= fq.dout;
      end
    end
  end
endmodule : dcc_ctrl
`default_nettype wire

/* File: dv/dcc_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl_checker (
  input wire logic        hclk,        // bus clock
  input wire logic        hresetn,     // reset, active low
  input wire logic        hsel,        // select
  input wire logic [31:0] haddr,       // address
  input wire logic [1:0]  htrans,      // transfer type
  input wire logic        hwrite,      // write
  input wire logic        hready,      // bus ready
  input wire logic [31:0] hwdata,      // write data
  input wire logic [31:0] hrdata,      // read data
  input wire logic        hreadyout,   // slave ready
  input wire logic        hresp,       // response
  input wire logic [9:0]  analog_data, // sample
  input wire logic        conv_strobe, // conversion start
  input wire logic        analog_on,   // core enable
  input wire logic        irq          // interrupt
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write address phase taken last cycle, with its offset
  logic [8:0] aw_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q <= 9'h000;
    end else begin
      aw_q <= {hsel && hready && htrans[1] && hwrite, haddr[7:0]};
    end
  end
  zero_wait_a: assert property (hreadyout == 1'b1 && hresp == 1'b0)
    else $error("bus answer not ready or not okay");
  strobe_enabled_a: assert property (conv_strobe |-> analog_on)
    else $error("conversion while converter off");
  irq_enabled_a: assert property (irq |-> analog_on)
    else $error("interrupt while converter off");
  data_on_strobe_a: assert property ($changed(analog_data) && analog_data != 10'h000 |-> conv_strobe)
    else $error("sample changed without strobe");
  hole_read_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h1C |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  soft_reset_a: assert property (aw_q == {1'b1, dcc_pkg::OFF_CTRL} && hwdata[0] |=> ##1 !analog_on && !irq)
    else $error("soft reset left converter running");
  mask_clear_a: assert property (aw_q == {1'b1, dcc_pkg::OFF_IRQ_DIS} && hwdata[0] |=> ##1 !irq)
    else $error("interrupt stayed after mask clear");
  disable_stop_a: assert property (aw_q == {1'b1, dcc_pkg::OFF_MODE} && !hwdata[4] |=> ##1 !analog_on && !conv_strobe)
    else $error("disable did not stop converter");
endmodule : dcc_ctrl_checker
bind dcc_ctrl dcc_ctrl_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .analog_data(analog_data), .conv_strobe(conv_strobe), .analog_on(analog_on), .irq(irq));
`default_nettype wire

/* File: dv/dcc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model (
  input  wire logic       hclk,        // bus clock
  input  wire logic [9:0] analog_data, // sample in
  input  wire logic       conv_strobe, // conversion start
  output logic            trig_pin,    // trigger pin
  output logic            event_in     // event pulse
);
  logic [9:0] got[$];
  time        at[$];
  initial begin
    trig_pin = 1'b0;
    event_in = 1'b0;
  end
  always @(posedge hclk) begin
    if (conv_strobe === 1'b1) begin
      got.push_back(analog_data);
      at.push_back($time);
    end
  end
  task automatic pin_pulse();
    @(posedge hclk) trig_pin <= 1'b1;
    repeat (2) @(posedge hclk);
    trig_pin <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : pin_pulse
  task automatic evt_pulse();
    @(posedge hclk) event_in <= 1'b1;
    @(posedge hclk) event_in <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : evt_pulse
endmodule : dcc_analog_model
`default_nettype wire

/* File: dv/test_dac_conversion_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dac_conversion_controller;
  localparam logic [7:0] SU = 8'h03;
  localparam int         DV = 6;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_strobe, analog_on, irq, trig_pin, event_in;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [9:0]  analog_data;
  int          miscompares, samples_checked;
  dcc_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trig_pin(trig_pin), .event_in(event_in), .analog_data(analog_data), .conv_strobe(conv_strobe),
    .analog_on(analog_on), .irq(irq));
  dcc_analog_model pm (.hclk(hclk), .analog_data(analog_data), .conv_strobe(conv_strobe), .trig_pin(trig_pin),
    .event_in(event_in));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(n, r, e);
  endtask : rd
  function automatic logic [31:0] md(logic en, logic ext, logic [2:0] src, logic word, logic [15:0] dv);
    return {dv, SU, 2'b00, word, en, src, ext};
  endfunction : md
  // mode write, then let any startup settle
  task automatic wm(logic [31:0] d);
    wr(dcc_pkg::OFF_MODE, d);
    repeat (8) @(posedge hclk);
  endtask : wm
  task automatic t_start();
    int k;
    wr(8'h1C, 32'hFFFF_FFFF);
    rd("hole", 8'h1C, 32'h0);
    wr(dcc_pkg::OFF_IRQ_EN, 32'h0);
    rd("mask0", dcc_pkg::OFF_IRQ_MASK, 32'h0);
    wr(dcc_pkg::OFF_IRQ_EN, 32'h1);
    wr(dcc_pkg::OFF_MODE, md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0));
    k = 0;
    while (irq !== 1'b1 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    chk("startup", 32'(k >= SU + 1 && k <= SU + 3), 32'h1);
    wr(dcc_pkg::OFF_IRQ_DIS, 32'h0);
    rd("mask1", dcc_pkg::OFF_IRQ_MASK, 32'h1);
    wr(dcc_pkg::OFF_IRQ_DIS, 32'h1);
    rd("mask2", dcc_pkg::OFF_IRQ_MASK, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask : t_start
  task automatic t_fifo();
    for (int i = 0; i < 4; i++) wr(dcc_pkg::OFF_DATA, {22'h3FFFFF, 10'(10'h150 + i)});
    rd("full", dcc_pkg::OFF_IRQ_STAT, 32'h0);
    repeat (4) pm.pin_pulse();
    for (int i = 0; i < 4; i++) chk("fifo", {22'h0, pm.got.pop_front()}, 32'(10'h150 + i));
    rd("room", dcc_pkg::OFF_IRQ_STAT, 32'h1);
    wm(md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b1, 16'h0));
    wr(dcc_pkg::OFF_DATA, 32'hFEAA_FCF0);
    repeat (2) pm.pin_pulse();
    chk("word0", {22'h0, pm.got.pop_front()}, 32'h0F0);
    chk("word1", {22'h0, pm.got.pop_front()}, 32'h2AA);
  endtask : t_fifo
  task automatic t_src();
    wm(md(1'b1, 1'b1, dcc_pkg::SRC_EVENT, 1'b0, 16'h0));
    wr(dcc_pkg::OFF_DATA, 32'h0000_0111);
    pm.pin_pulse();
    chk("evt_pin", 32'(pm.got.size()), 32'h0);
    pm.evt_pulse();
    chk("evt", {22'h0, pm.got.pop_front()}, 32'h111);
    wm(md(1'b1, 1'b1, 3'h2, 1'b0, 16'h0));
    wr(dcc_pkg::OFF_DATA, 32'h0000_0222);
    pm.pin_pulse();
    pm.evt_pulse();
    chk("rsvd", 32'(pm.got.size()), 32'h0);
    wm(md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0));
    pm.pin_pulse();
    chk("pin", {22'h0, pm.got.pop_front()}, 32'h222);
  endtask : t_src
  task automatic t_int();
    pm.at.delete();
    wm(md(1'b1, 1'b0, 3'h0, 1'b0, 16'(DV)));
    repeat (3 * DV) @(posedge hclk);
    chk("idle", 32'(pm.got.size()), 32'h0);
    wr(dcc_pkg::OFF_DATA, 32'h0000_0123);
    wr(dcc_pkg::OFF_DATA, 32'h0000_0321);
    repeat (4 * DV) @(posedge hclk);
    chk("ticks", 32'(pm.got.size()), 32'h2);
    chk("period", 32'(pm.at[1] - pm.at[0]), 32'(DV * 25));
    pm.got.delete();
    pm.at.delete();
  endtask : t_int
  task automatic t_dis();
    wm(md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0));
    wr(dcc_pkg::OFF_DATA, 32'h0000_0333);
    wr(dcc_pkg::OFF_IRQ_EN, 32'h1);
    wm(md(1'b0, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0));
    rd("dis", dcc_pkg::OFF_IRQ_STAT, 32'h0);
    chk("dis_irq", {31'h0, irq}, 32'h0);
    wm(md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0));
    pm.pin_pulse();
    chk("flush", 32'(pm.got.size()), 32'h0);
  endtask : t_dis
  task automatic t_prot();
    wr(dcc_pkg::OFF_WP_MODE, 32'h1234_5601);
    wr(dcc_pkg::OFF_MODE, md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0077));
    rd("nokey", dcc_pkg::OFF_MODE, md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0077));
    wr(dcc_pkg::OFF_WP_MODE, {dcc_pkg::PROTECT_KEY, 8'h01});
    rd("wpon", dcc_pkg::OFF_WP_MODE, 32'h1);
    wr(dcc_pkg::OFF_MODE, md(1'b1, 1'b0, 3'h0, 1'b1, 16'h0055));
    rd("locked", dcc_pkg::OFF_MODE, md(1'b1, 1'b1, dcc_pkg::SRC_PIN, 1'b0, 16'h0077));
    rd("err", dcc_pkg::OFF_WP_STAT, 32'h1);
    rd("errclr", dcc_pkg::OFF_WP_STAT, 32'h0);
    wr(dcc_pkg::OFF_CTRL, 32'h0);
    rd("nosrst", dcc_pkg::OFF_WP_MODE, 32'h1);
    wr(dcc_pkg::OFF_IRQ_EN, 32'h1);
    wr(dcc_pkg::OFF_CTRL, 32'h1);
    rd("srst_md", dcc_pkg::OFF_MODE, 32'h0);
    rd("srst_mk", dcc_pkg::OFF_IRQ_MASK, 32'h0);
    rd("srst_wp", dcc_pkg::OFF_WP_MODE, 32'h0);
  endtask : t_prot
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_start();
    t_fifo();
    t_src();
    t_int();
    t_dis();
    t_prot();
    wr(dcc_pkg::OFF_MODE, 32'h0);
    test_done();
  end
endmodule : test_dac_conversion_controller
`default_nettype wire
